// ### lvd_irq.sv
// Low-voltage detector control, level flag and interrupt logic
// Operation
// [R1] With the action mode bit at 0 (default) a crossing raises an interrupt, not a reset.
// [R2] The source select bit picks the supply comparator (0) or the external input (1).
// [R3] Detection runs only while the enable bit is 1; setting it starts detection.
// [R4] The 4-bit threshold level field selects the supply detection threshold.
// [R5] Software waits at least 10 us after enabling before using the flag or unmasking.
// [R6] The level flag shows the present comparison; software checks it before arming.
// [R7] Software arms in order: mask, source, level, mode, enable, wait, check, clear, unmask.
// [R8] An interrupt request is raised both on falling below and on returning above.
// [R9] Software stops the detector by writing zero to control or clearing enable.
// [R10] Clearing enable while below the threshold raises a request and sets its flag.
// [R11] Reset sets the detect interrupt mask to 1.
// [R12] A crossing that raises a request may set both level flag and request flag.
// [R13] The service routine checks the level flag, then clears request flag bit 0.
// [R14] On a hovering supply, software waits out fluctuation before port setup.
// [R15] The comparator result is synchronised; each change while enabled gives one pulse.
`timescale 1ns/1ps
module lvd_irq
  import lvd_irq_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic                                CLK_I,
  input  wire logic                                RST_B_I,
  input  wire logic [ADDR_W-1:0]                   S_AXI_AWADDR_I,
  input  wire logic                                S_AXI_AWVALID_I,
  output logic                                     S_AXI_AWREADY_O,
  input  wire logic [31:0]                         S_AXI_WDATA_I,
  input  wire logic [3:0]                          S_AXI_WSTRB_I,
  input  wire logic                                S_AXI_WVALID_I,
  output logic                                     S_AXI_WREADY_O,
  output logic [1:0]                               S_AXI_BRESP_O,
  output logic                                     S_AXI_BVALID_O,
  input  wire logic                                S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0]                   S_AXI_ARADDR_I,
  input  wire logic                                S_AXI_ARVALID_I,
  output logic                                     S_AXI_ARREADY_O,
  output logic [31:0]                              S_AXI_RDATA_O,
  output logic [1:0]                               S_AXI_RRESP_O,
  output logic                                     S_AXI_RVALID_O,
  input  wire logic                                S_AXI_RREADY_I,
  input  wire logic                                SUPPLY_BELOW_I,
  input  wire logic                                EXTERNAL_DETECT_INPUT_BELOW_I,
  output logic                                     DETECTOR_ENABLE_O,
  output logic                                     SOURCE_SELECT_O,
  output logic [lvd_irq_pkg::THRESHOLD_LEVEL_W-1:0] THRESHOLD_LEVEL_O,
  output logic                                     LOW_VOLTAGE_RESET_REQ_O,
  output logic                                     DETECT_IRQ_SIGNAL_O,
  output logic                                     IRQ_O
);

  import lvd_irq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                         detector_enable;
  logic                         source_select;
  logic                         detect_action_mode;
  logic [THRESHOLD_LEVEL_W-1:0] threshold_level_field;
  logic                         detect_irq_request;
  logic                         detect_irq_mask;
  logic                         detect_irq_signal;
  logic                         prev_level;
  logic [SETTLE_CNT_W-1:0]      settle_cnt;
  logic [1:0]                   cmp_sync;
  logic [ADDR_W-1:0]            aw_addr;
  logic                         aw_held;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         w_held;
  logic [31:0]                  rdata;
  logic [1:0]                   rresp;
  logic                         rvalid;
  logic [1:0]                   bresp;
  logic                         bvalid;

  // Register index from a byte address; unmapped gives 3'h4
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [3:0] a;
    a = addr[3:0];
    if (addr[1:0] != 2'h0) begin
      reg_index = 3'h4;
    end else if (a == OFS_DETECTOR_CONTROL) begin
      reg_index = 3'h0;
    end else if (a == OFS_THRESHOLD_SELECT) begin
      reg_index = 3'h1;
    end else if (a == OFS_IRQ_FLAG_LOW0) begin
      reg_index = 3'h2;
    end else if (a == OFS_IRQ_MASK) begin
      reg_index = 3'h3;
    end else begin
      reg_index = 3'h4;
    end
  endfunction

  // ----------------------------------------------------------------
  // Comparator synchronisation and level flag
  // ----------------------------------------------------------------
  lvd_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .async_i ({EXTERNAL_DETECT_INPUT_BELOW_I, SUPPLY_BELOW_I}),
    .sync_o  (cmp_sync)
  ); // R15

  // Flag reads 1 while enabled and the chosen input is below its threshold
  wire selected_below = source_select ? cmp_sync[1] : cmp_sync[0]; // R2
  wire level_flag     = detector_enable & selected_below;          // R3 R6
  // Disabling drops the flag, so a disable while below is a change too
  wire level_change   = level_flag ^ prev_level;                   // R8 R10
  wire raise_request  = level_change & ~detect_action_mode;        // R1
  wire settled        = detector_enable && (settle_cnt == SETTLE_CNT_W'(SETTLE_CYCLES));

  // ----------------------------------------------------------------
  // Write path decode
  // ----------------------------------------------------------------
  wire       do_write   = aw_held & w_held & ~bvalid;
  wire [2:0] wr_index   = reg_index(aw_addr);
  wire       wr_lane0   = do_write & w_strb[0];
  wire       wr_control = wr_lane0 & (wr_index == 3'h0);
  wire       wr_thresh  = wr_lane0 & (wr_index == 3'h1);
  wire       wr_flag    = wr_lane0 & (wr_index == 3'h2);
  wire       wr_mask    = wr_lane0 & (wr_index == 3'h3);
  wire       clear_req  = wr_flag & w_data[BIT_DETECT_IRQ];
  // Hardware set wins over a write-one clear in the same cycle
  wire       next_req   = (detect_irq_request & ~clear_req) | detect_irq_signal; // R12

  // ----------------------------------------------------------------
  // Read path decode
  // ----------------------------------------------------------------
  wire       ar_take  = S_AXI_ARVALID_I & ~rvalid;
  wire [2:0] rd_index = reg_index(S_AXI_ARADDR_I);
  wire [7:0] rd_control = {detector_enable, 3'h0, settled, source_select,
                           detect_action_mode, level_flag};
  wire [31:0] next_rdata =
    (rd_index == 3'h0) ? {24'h0, rd_control} :
    (rd_index == 3'h1) ? {28'h0, threshold_level_field} :
    (rd_index == 3'h2) ? {31'h0, detect_irq_request} :
    (rd_index == 3'h3) ? {31'h0, detect_irq_mask} : 32'h0;
  wire [1:0] next_rresp = (rd_index == 3'h4) ? RESP_SLVERR : RESP_OKAY;

  // ----------------------------------------------------------------
  // Bus handshake outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY_O = ~aw_held & ~bvalid;
  assign S_AXI_WREADY_O  = ~w_held & ~bvalid;
  assign S_AXI_ARREADY_O = ~rvalid;
  assign S_AXI_BVALID_O  = bvalid;
  assign S_AXI_BRESP_O   = bresp;
  assign S_AXI_RVALID_O  = rvalid;
  assign S_AXI_RDATA_O   = rdata;
  assign S_AXI_RRESP_O   = rresp;

  // ----------------------------------------------------------------
  // Block outputs
  // ----------------------------------------------------------------
  assign DETECTOR_ENABLE_O       = detector_enable;
  assign SOURCE_SELECT_O         = source_select;
  assign THRESHOLD_LEVEL_O       = threshold_level_field; // R4
  assign DETECT_IRQ_SIGNAL_O     = detect_irq_signal;
  // Reset action is only requested; the reset path itself lives elsewhere
  assign LOW_VOLTAGE_RESET_REQ_O = level_flag & detect_action_mode; // R1
  assign IRQ_O                   = detect_irq_request & ~detect_irq_mask;

  // ----------------------------------------------------------------
  // Write address and data capture, taken in either order
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are in
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (wr_index == 3'h4) ? RESP_SLVERR : RESP_OKAY;
    end else if (S_AXI_BREADY_I) begin
      bvalid <= 1'b0;
    end
  end

  // Read data registered; held until the master takes it
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (S_AXI_RREADY_I) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control and threshold registers
  // ----------------------------------------------------------------
  // Threshold is not guarded while running; software keeps it steady
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      detector_enable       <= RST_DETECTOR_ENABLE;
      source_select         <= RST_SOURCE_SELECT;
      detect_action_mode    <= RST_DETECT_ACTION_MODE;
      threshold_level_field <= RST_THRESHOLD_LEVEL;
    end else begin
      if (wr_control) begin
        detector_enable    <= w_data[BIT_DETECTOR_ENABLE]; // R3 R9
        source_select      <= w_data[BIT_SOURCE_SELECT];   // R2
        detect_action_mode <= w_data[BIT_DETECT_ACTION_MODE]; // R1
      end
      if (wr_thresh) begin
        threshold_level_field <= w_data[THRESHOLD_LEVEL_W-1:0]; // R4
      end
    end
  end

  // Stabilisation counter, restarts each time the detector is enabled
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      settle_cnt <= '0;
    end else if (!detector_enable) begin
      settle_cnt <= '0;
    end else if (!settled) begin
      settle_cnt <= settle_cnt + SETTLE_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Edge detection, request pulse, sticky flag and mask
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prev_level         <= 1'b0;
      detect_irq_signal  <= 1'b0;
      detect_irq_request <= RST_DETECT_IRQ_REQ;
      detect_irq_mask    <= RST_DETECT_IRQ_MASK; // R11
    end else begin
      prev_level         <= level_flag;
      detect_irq_signal  <= raise_request; // R8 R15
      detect_irq_request <= next_req;      // R10 R12
      if (wr_mask) begin
        detect_irq_mask <= w_data[BIT_DETECT_IRQ];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_disable_below;
    $fell(detector_enable) && $past(level_flag) && !detect_action_mode;
  endsequence
  sequence s_pulse_then_flag;
    ##1 detect_irq_signal ##1 detect_irq_request;
  endsequence

  a_mask_at_reset: assert property (disable iff (1'b0) // R11
    $rose(RST_B_I) |-> detect_irq_mask)
    else $error("mask not set after reset");

  a_crossing_pulse: assert property ( // R8
    ($changed(level_flag) && !detect_action_mode) |=> detect_irq_signal)
    else $error("level change gave no request pulse");

  a_pulse_sets_flag: assert property ( // R12
    detect_irq_signal |=> detect_irq_request)
    else $error("request pulse did not set request flag");

  a_disable_while_below: assert property (s_disable_below |-> s_pulse_then_flag) // R10
    else $error("disable while below raised no request");

  a_idle_no_pulse: assert property ( // R3
    (!detector_enable) [*3] |-> !detect_irq_signal && !level_flag)
    else $error("pulse or flag while detector disabled");

  a_reset_mode_quiet: assert property ( // R1
    detect_action_mode [*2] |-> !detect_irq_signal)
    else $error("interrupt pulse in reset action mode");

  a_source_external: assert property ( // R2
    (detector_enable && source_select && $stable(cmp_sync))
      |-> level_flag == cmp_sync[1])
    else $error("external source not reflected in level flag");

  a_single_pulse: assert property ( // R15
    (detect_irq_signal && $stable(level_flag)) |=> !detect_irq_signal)
    else $error("request pulse longer than one cycle");

  a_threshold_write: assert property ( // R4
    wr_thresh |=> THRESHOLD_LEVEL_O == $past(w_data[3:0]))
    else $error("threshold field not written");

  a_flag_clear: assert property ( // R13
    (clear_req && !detect_irq_signal) |=> !detect_irq_request)
    else $error("request flag not cleared by write one");

  a_irq_out: assert property ( // R11
    (detect_irq_request && !detect_irq_mask) |-> IRQ_O)
    else $error("unmasked request not on interrupt line");

  // Control fields take the written bits one cycle after the write lands
  a_enable_write: assert property ( // R3 R9
    wr_control |=> detector_enable == $past(w_data[BIT_DETECTOR_ENABLE]))
    else $error("enable bit not written");

  a_mode_write: assert property ( // R1
    wr_control |=> detect_action_mode == $past(w_data[BIT_DETECT_ACTION_MODE]))
    else $error("action mode bit not written");

  a_source_write: assert property ( // R2
    wr_control |=> source_select == $past(w_data[BIT_SOURCE_SELECT]))
    else $error("source select bit not written");

endmodule

// ### lvd_irq_pkg.sv
// Constants shared by the low-voltage detect interrupt block
package lvd_irq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AXI4-Lite bus
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_DETECTOR_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_THRESHOLD_SELECT  = 4'h4;
  localparam logic [3:0] OFS_IRQ_FLAG_LOW0     = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK          = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LEVEL_FLAG         = 0;
  localparam int BIT_DETECT_ACTION_MODE = 1;
  localparam int BIT_SOURCE_SELECT      = 2;
  localparam int BIT_DETECTOR_SETTLED   = 3;
  localparam int BIT_DETECTOR_ENABLE    = 7;
  localparam int BIT_DETECT_IRQ         = 0;
  localparam int THRESHOLD_LEVEL_W      = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic       RST_DETECT_ACTION_MODE = 1'b0;
  localparam logic       RST_SOURCE_SELECT      = 1'b0;
  localparam logic       RST_DETECTOR_ENABLE    = 1'b0;
  localparam logic [3:0] RST_THRESHOLD_LEVEL    = 4'h0;
  localparam logic       RST_DETECT_IRQ_MASK    = 1'b1;
  localparam logic       RST_DETECT_IRQ_REQ     = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 20000;
  localparam int SETTLE_TIME_US   = 10;
  localparam int SETTLE_CYCLES    =
    (SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CNT_W     = $clog2(SETTLE_CYCLES + 1);

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### lvd_sync2.sv
// Two-flop synchroniser for the comparator result levels
`timescale 1ns/1ps
module lvd_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // First stage feeds only the second stage, to let metastability settle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ### lvd_irq_test.sv
// Self-checking testbench for the low-voltage detect interrupt block
`timescale 1ns/1ps
module lvd_irq_test;
  import lvd_irq_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        supply_below = 1'b0, ext_below = 1'b0;
  logic        det_en, src_sel, rst_req, det_pulse, irq;
  logic [3:0]  level;
  int          fails = 0, n_checks = 0, pulses = 0, p0 = 0;

  lvd_irq u_dut (
    .CLK_I(clk), .RST_B_I(rst_b),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .SUPPLY_BELOW_I(supply_below), .EXTERNAL_DETECT_INPUT_BELOW_I(ext_below),
    .DETECTOR_ENABLE_O(det_en), .SOURCE_SELECT_O(src_sel), .THRESHOLD_LEVEL_O(level),
    .LOW_VOLTAGE_RESET_REQ_O(rst_req), .DETECT_IRQ_SIGNAL_O(det_pulse), .IRQ_O(irq)
  );

  // Clock and pulse counter; the count proves each pulse lasts one cycle
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (det_pulse === 1'b1) pulses <= pulses + 1;
  end

  // ----------------------------------------------------------------
  // Reporting and compares
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t bus response got %h exp %h", $time, got, exp);
    end
  endtask

  // A wait that ran out of its bound ends the run
  task automatic to_chk(input logic ok);
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t bus wait timed out", $time);
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // AXI4-Lite master; ready is looked at mid-cycle, where it is settled
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_ok, w_ok, ra, rw, h;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    a_ok = 1'b0; w_ok = 1'b0; h = 1'b0;
    for (n = 0; n < 50 && !(a_ok && w_ok); n++) begin
      @(negedge clk); ra = awready & ~a_ok; rw = wready & ~w_ok;
      @(posedge clk);
      if (ra) begin awvalid <= 1'b0; a_ok = 1'b1; end
      if (rw) begin wvalid <= 1'b0; w_ok = 1'b1; end
    end
    to_chk(a_ok && w_ok);
    for (n = 0; n < 50 && !h; n++) begin
      @(negedge clk); h = bvalid; r = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    to_chk(h);
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic h;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    h = 1'b0;
    for (n = 0; n < 50 && !h; n++) begin
      @(negedge clk); h = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    to_chk(h);
    h = 1'b0;
    for (n = 0; n < 50 && !h; n++) begin
      @(negedge clk); h = rvalid; d = rdata; r = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    to_chk(h);
  endtask

  // Register access expecting OKAY, and a read compared with its value
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_resp(r, RESP_OKAY);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [1:0]  r;
    logic [31:0] d;
    axi_read(a, d, r);
    chk_resp(r, RESP_OKAY);
    chk(d, exp, what);
  endtask

  // Wait out the comparator path and count the pulses since the last call
  task automatic pulse_chk(input int exp);
    repeat (8) @(posedge clk);
    chk(32'(pulses - p0), 32'(exp), "pulse count");
    p0 = pulses;
  endtask

  task automatic enable_and_settle(input logic [31:0] ctrl);
    wr(OFS_DETECTOR_CONTROL, ctrl);
    repeat (SETTLE_CYCLES + 10) @(posedge clk);
    p0 = pulses;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_DETECTOR_CONTROL, 32'h0, "control after reset");
    rd(OFS_IRQ_MASK, 32'h1, "mask after reset");
    rd(OFS_IRQ_FLAG_LOW0, 32'h0, "request after reset");
    wr(OFS_THRESHOLD_SELECT, 32'hFA);
    rd(OFS_THRESHOLD_SELECT, 32'hA, "threshold");
    chk(32'(level), 32'hA, "threshold out");
    $display("test reset and threshold done");

    // Supply source, both crossing directions, mask and clear
    enable_and_settle(32'h80);
    chk(32'(det_en), 32'h1, "enable out");
    rd(OFS_DETECTOR_CONTROL, 32'h88, "control above");
    wr(OFS_IRQ_FLAG_LOW0, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0, "irq idle");
    @(posedge clk); supply_below <= 1'b1;
    pulse_chk(1);
    chk(32'(irq), 32'h1, "irq on fall");
    rd(OFS_DETECTOR_CONTROL, 32'h89, "control below");
    wr(OFS_IRQ_FLAG_LOW0, 32'h1);
    rd(OFS_IRQ_FLAG_LOW0, 32'h0, "request cleared");
    chk(32'(irq), 32'h0, "irq cleared");
    wr(OFS_IRQ_MASK, 32'h1);
    @(posedge clk); supply_below <= 1'b0;
    pulse_chk(1);
    chk(32'(irq), 32'h0, "irq masked");
    rd(OFS_IRQ_FLAG_LOW0, 32'h1, "request on rise");
    wr(OFS_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(OFS_IRQ_FLAG_LOW0, 32'h1);
    $display("test supply crossings done");

    // Disable while below: a request still comes
    @(posedge clk); supply_below <= 1'b1;
    pulse_chk(1);
    wr(OFS_IRQ_FLAG_LOW0, 32'h1);
    wr(OFS_DETECTOR_CONTROL, 32'h0);
    pulse_chk(1);
    rd(OFS_IRQ_FLAG_LOW0, 32'h1, "request on disable");
    wr(OFS_IRQ_FLAG_LOW0, 32'h1);
    @(posedge clk); supply_below <= 1'b0;
    pulse_chk(0);
    rd(OFS_IRQ_FLAG_LOW0, 32'h0, "no request when off");
    $display("test disable done");

    // External source ignores the supply
    enable_and_settle(32'h84);
    chk(32'(src_sel), 32'h1, "source out");
    @(posedge clk); supply_below <= 1'b1;
    pulse_chk(0);
    @(posedge clk); ext_below <= 1'b1;
    pulse_chk(1);
    rd(OFS_DETECTOR_CONTROL, 32'h8D, "control external");
    chk(32'(rst_req), 32'h0, "no reset in irq mode");
    @(posedge clk); ext_below <= 1'b0;
    pulse_chk(1);
    $display("test external source done");

    // Reset action mode: no pulses, reset request instead
    wr(OFS_DETECTOR_CONTROL, 32'h86);
    @(posedge clk); ext_below <= 1'b1;
    pulse_chk(0);
    chk(32'(rst_req), 32'h1, "reset request");
    wr(OFS_DETECTOR_CONTROL, 32'h0);
    chk(32'(rst_req), 32'h0, "stopped");
    $display("test action mode done");

    // Misaligned places answer with an error
    axi_write(4'h2, 32'h1, r);
    chk_resp(r, RESP_SLVERR);
    axi_read(4'h6, d, r);
    chk_resp(r, RESP_SLVERR);
    chk(d, 32'h0, "unmapped read");
    $display("test unmapped done");

    // Second reset in mid-run puts the mask back
    wr(OFS_IRQ_MASK, 32'h0);
    @(posedge clk); rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_IRQ_MASK, 32'h1, "mask after second reset");
    rd(OFS_THRESHOLD_SELECT, 32'h0, "threshold after reset");
    $display("test second reset done");
    finish_test();
  end
endmodule
